// ===== rtl/lic_core.v
// Local interrupt controller core: message acceptance, local vector table, errors and command sends
`timescale 1ns/1ns
`include "lic_defs.vh"

// Overview of operation
// RULE1: Clearing enable keeps registers but sets every local vector table mask.
// RULE2: While disabled, only startup-reset, system-management, NMI and start-up messages accepted.
// RULE3: NMI and startup-reset always edge triggered, except startup-reset deassert.
// RULE4: Command register sends are edge triggered, except startup-reset deassert.
// RULE5: Logical destination register is 8 bits and matches logical messages.
// RULE6: Identifier is 4 bits in the earlier variant, 8 in the later.
// RULE7: Later variant never services remote-read messages.
// RULE8: Lowest-priority arbitration joined only when a free interrupt slot exists.
// RULE9: Logical destination mode supports cluster addressing.
// RULE10: Software enables or disables focus-processor checking.
// RULE11: Later variant never delivers lowest-priority interrupts to a focus processor.
// RULE12: Each local pin has its own programmable active polarity.
// RULE13: System-management messages are accepted and can be sent by the command register.
// RULE14: Error status register logs errors and reports them via a local interrupt.
// RULE15: A vector table entry delivers performance counter interrupts.
// RULE16: Later variant has a vector table entry for thermal sensor interrupts.
// RULE17: Later variant does not support the flat cluster logical form.
// RULE18: After re-enable, masks stay set until software clears them.
module lic_core #(
    parameter LATER_VARIANT = 1
)(
    input wire clk,
    input wire sys_rst,
    input wire sw_enable,
    input wire focus_chk_en,
    input wire cluster_mode,
    input wire flat_cluster,
    input wire [1:0] pin_active_low,
    input wire id_wr,
    input wire [7:0] id_wr_val,
    input wire ldest_wr,
    input wire [7:0] ldest_wr_val,
    input wire lvt_wr,
    input wire [2:0] lvt_wr_sel,
    input wire [7:0] lvt_wr_vec,
    input wire lvt_wr_mask,
    input wire local_pin0,
    input wire local_pin1,
    input wire perf_evt,
    input wire therm_evt,
    input wire [7:0] err_evt,
    input wire esr_clear,
    input wire msg_valid,
    input wire [2:0] msg_mode,
    input wire msg_level,
    input wire msg_deassert,
    input wire msg_logical,
    input wire [7:0] msg_dest,
    input wire [7:0] msg_vec,
    input wire icr_go,
    input wire [2:0] icr_mode,
    input wire icr_level,
    input wire icr_deassert,
    input wire [7:0] icr_vec,
    input wire [7:0] icr_dest,
    input wire core_ack,
    output wire msg_accept,
    output wire msg_lowpri_bid,
    output wire msg_focus,
    output reg rread_valid_r,
    output reg [7:0] rread_data_r,
    output reg [4:0] lvt_mask_r,
    output reg [7:0] esr_r,
    output reg [7:0] id_r,
    output reg [7:0] ldest_r,
    output reg core_intr_r,
    output reg [7:0] core_vec_r,
    output reg core_level_r,
    output reg core_nmi_r,
    output reg core_smi_r,
    output reg core_init_r,
    output reg core_start_r,
    output reg [7:0] core_start_vec_r,
    output reg send_valid_r,
    output reg [2:0] send_mode_r,
    output reg send_level_r,
    output reg [7:0] send_vec_r,
    output reg [7:0] send_dest_r
);

// ******************************
// Variant dependent widths
// ******************************
localparam ID_W = LATER_VARIANT ? `LIC_ID_W_LATE : `LIC_ID_W_EARLY;
// Upper identifier bits read as zero in the narrow variant
localparam [7:0] ID_KEEP = 8'hFF >> (`LIC_ID_W_LATE - ID_W);

// ******************************
// State
// ******************************
reg [7:0] lvt_vec_r [0:`LIC_LVT_N-1];
reg [4:0] lvt_pend_r;
reg [4:0] lvt_pend_nxt;
reg [1:0] pin_s1_r;
reg [1:0] pin_s2_r;
reg [1:0] pin_q_r;
reg [7:0] esr_nxt;
reg [7:0] slot_vec_nxt;
reg slot_fill;
reg slot_level_nxt;
reg [2:0] pick;
integer i;
integer k;

// ******************************
// Local pin synchronisers and polarity
// ******************************
wire [1:0] pin_act = pin_s2_r ^ pin_active_low; // RULE12
wire [1:0] pin_rise = pin_act & ~pin_q_r;

always @(posedge clk)
begin
    if (sys_rst)
    begin
        pin_s1_r <= 2'h0;
        pin_s2_r <= 2'h0;
        // Reads as already active, so no false edge follows reset
        pin_q_r <= 2'h3;
    end
    else
    begin
        pin_s1_r <= {local_pin1, local_pin0};
        pin_s2_r <= pin_s1_r;
        pin_q_r <= pin_act;
    end
end

// ******************************
// Destination matching
// ******************************
wire [7:0] id_full = id_r & ID_KEEP; // RULE6
// All-ones destination reaches every controller
wire phys_hit = (msg_dest == `LIC_BCAST) || (msg_dest == id_full);
wire [3:0] mem_and = msg_dest[3:0] & ldest_r[3:0];
wire clu_same = msg_dest[`LIC_CLUSTER_HI:`LIC_CLUSTER_LO] == ldest_r[`LIC_CLUSTER_HI:`LIC_CLUSTER_LO];
// Flat cluster ignores the cluster field; the later variant drops it
wire flat_ok = flat_cluster && (LATER_VARIANT == 0); // RULE17
wire clu_hit = (clu_same || flat_ok || msg_dest == `LIC_BCAST) && (mem_and != 4'h0); // RULE9
wire flat_hit = (msg_dest & ldest_r) != 8'h00; // RULE5
wire log_hit = cluster_mode ? clu_hit : flat_hit;
wire dest_hit = msg_logical ? log_hit : phys_hit;

// ******************************
// Message acceptance
// ******************************
wire is_fixed = msg_mode == `LIC_MODE_FIXED;
wire is_lowpri = msg_mode == `LIC_MODE_LOWPRI;
wire is_rread = msg_mode == `LIC_MODE_RREAD;
wire is_nmi = msg_mode == `LIC_MODE_NMI;
wire is_init = msg_mode == `LIC_MODE_INIT;
wire is_start = msg_mode == `LIC_MODE_START;
wire is_smi = msg_mode == `LIC_MODE_SMI;
wire sys_kind = is_nmi || is_init || is_start || is_smi; // RULE2 RULE13
// One slot: while it is full, fixed is refused and lowest-priority is taken only on a focus match
wire slot_free = !core_intr_r;
wire focus_on = focus_chk_en && (LATER_VARIANT == 0); // RULE10 RULE11
wire focus_match = focus_on && core_intr_r && (core_vec_r == msg_vec);
wire hit_v = msg_valid && dest_hit;

assign msg_lowpri_bid = hit_v && is_lowpri && sw_enable && slot_free; // RULE8
assign msg_focus = hit_v && is_lowpri && sw_enable && focus_match; // RULE11
wire acc_slot = hit_v && sw_enable && slot_free && (is_fixed || is_lowpri); // RULE2
wire acc_rread = hit_v && sw_enable && is_rread && (LATER_VARIANT == 0); // RULE7
// Reply is the vector table word, or error status past the table
wire [2:0] rread_sel = msg_vec[2:0];
wire [7:0] rread_word = (rread_sel < `LIC_LVT_N) ? lvt_vec_r[rread_sel] : esr_r;
wire acc_sys = hit_v && sys_kind; // RULE2
assign msg_accept = acc_slot || acc_rread || acc_sys || msg_focus;
// Level programming on NMI and plain startup-reset is ignored
wire forced_edge = is_nmi || (is_init && !msg_deassert); // RULE3
wire msg_trig = msg_level && !forced_edge;

// ******************************
// Local vector table and errors
// ******************************
wire err_any = |err_evt;
wire therm_ok = therm_evt && (LATER_VARIANT != 0); // RULE16
wire [4:0] lvt_evt = {therm_ok, perf_evt, err_any, pin_rise}; // RULE15

// ******************************
// Pending events and slot fill
// ******************************
always @*
begin
    esr_nxt = esr_r;
    if (esr_clear)
    begin
        esr_nxt = 8'h00;
    end
    // New errors win over a clear in the same cycle
    esr_nxt = esr_nxt | err_evt; // RULE14
    lvt_pend_nxt = lvt_pend_r | (lvt_evt & ~lvt_mask_r); // RULE14
    pick = 3'h0;
    slot_fill = 1'b0;
    slot_vec_nxt = core_vec_r;
    slot_level_nxt = core_level_r;
    if (acc_slot)
    begin
        slot_fill = 1'b1;
        slot_vec_nxt = msg_vec;
        slot_level_nxt = msg_trig;
    end
    else if (slot_free && lvt_pend_r != 5'h00)
    begin
        for (i = `LIC_LVT_N - 1; i >= 0; i = i - 1)
        begin
            if (lvt_pend_r[i])
            begin
                pick = i[2:0];
            end
        end
        slot_fill = 1'b1;
        slot_vec_nxt = lvt_vec_r[pick];
        slot_level_nxt = 1'b0;
        lvt_pend_nxt[pick] = lvt_evt[pick] && !lvt_mask_r[pick];
    end
end

// ******************************
// Register file and slot
// ******************************
always @(posedge clk)
begin
    if (sys_rst)
    begin
        lvt_mask_r <= `LIC_LVT_MASK_RST;
        lvt_pend_r <= 5'h00;
        esr_r <= 8'h00;
        id_r <= 8'h00;
        ldest_r <= 8'h00;
        core_intr_r <= 1'b0;
        core_vec_r <= 8'h00;
        core_level_r <= 1'b0;
        for (k = 0; k < `LIC_LVT_N; k = k + 1)
        begin
            lvt_vec_r[k] <= 8'h00;
        end
    end
    else
    begin
        esr_r <= esr_nxt;
        lvt_pend_r <= lvt_pend_nxt & ~lvt_mask_r;
        if (id_wr)
        begin
            id_r <= id_wr_val & ID_KEEP; // RULE6
        end
        if (ldest_wr)
        begin
            ldest_r <= ldest_wr_val; // RULE5
        end
        if (lvt_wr && lvt_wr_sel < `LIC_LVT_N)
        begin
            lvt_vec_r[lvt_wr_sel] <= lvt_wr_vec;
            lvt_mask_r[lvt_wr_sel] <= lvt_wr_mask; // RULE18
        end
        // Disable forces masks only; pending local events drop a cycle later, other state is kept for re-enable
        if (!sw_enable)
        begin
            lvt_mask_r <= `LIC_LVT_MASK_RST; // RULE1
        end
        if (slot_fill)
        begin
            core_intr_r <= 1'b1;
            core_vec_r <= slot_vec_nxt;
            core_level_r <= slot_level_nxt;
        end
        else if (core_ack)
        begin
            core_intr_r <= 1'b0;
        end
    end
end

// ******************************
// System messages to the core
// ******************************
always @(posedge clk)
begin
    if (sys_rst)
    begin
        core_nmi_r <= 1'b0;
        core_smi_r <= 1'b0;
        core_init_r <= 1'b0;
        core_start_r <= 1'b0;
        core_start_vec_r <= 8'h00;
        rread_valid_r <= 1'b0;
        rread_data_r <= 8'h00;
    end
    else
    begin
        core_nmi_r <= acc_sys && is_nmi; // RULE3
        core_smi_r <= acc_sys && is_smi; // RULE13
        // Deassert only ends a level; it never restarts the core
        core_init_r <= acc_sys && is_init && !msg_deassert; // RULE3
        core_start_r <= acc_sys && is_start;
        if (acc_sys && is_start)
        begin
            core_start_vec_r <= msg_vec;
        end
        rread_valid_r <= acc_rread; // RULE7
        if (acc_rread)
        begin
            rread_data_r <= rread_word;
        end
    end
end

// ******************************
// Command register sends
// ******************************
// Only a startup-reset deassert may leave as a level
wire icr_level_ok = icr_level && icr_deassert && (icr_mode == `LIC_MODE_INIT); // RULE4

always @(posedge clk)
begin
    if (sys_rst)
    begin
        send_valid_r <= 1'b0;
        send_mode_r <= `LIC_MODE_FIXED;
        send_level_r <= 1'b0;
        send_vec_r <= 8'h00;
        send_dest_r <= 8'h00;
    end
    else
    begin
        send_valid_r <= icr_go; // RULE13
        if (icr_go)
        begin
            send_mode_r <= icr_mode;
            send_level_r <= icr_level_ok; // RULE4
            send_vec_r <= icr_vec;
            send_dest_r <= icr_dest;
        end
    end
end

endmodule

// ===== rtl/lic_defs.vh
// Constants for the local interrupt controller core
`ifndef LIC_DEFS_VH
`define LIC_DEFS_VH
// ******************************
// Delivery modes
// ******************************
`define LIC_MODE_W 3
`define LIC_MODE_FIXED 3'h0
`define LIC_MODE_LOWPRI 3'h1
`define LIC_MODE_SMI 3'h2
`define LIC_MODE_RREAD 3'h3
`define LIC_MODE_NMI 3'h4
`define LIC_MODE_INIT 3'h5
`define LIC_MODE_START 3'h6
// ******************************
// Local vector table entries
// ******************************
`define LIC_LVT_N 5
`define LIC_LVT_SEL_W 3
`define LIC_LVT_PIN0 3'h0
`define LIC_LVT_PIN1 3'h1
`define LIC_LVT_ERR 3'h2
`define LIC_LVT_PERF 3'h3
`define LIC_LVT_THERM 3'h4
`define LIC_LVT_MASK_RST 5'h1F
// ******************************
// Widths and reset values
// ******************************
`define LIC_LDEST_W 8
`define LIC_ID_W_EARLY 4
`define LIC_ID_W_LATE 8
`define LIC_ESR_W 8
`define LIC_VEC_W 8
`define LIC_BCAST 8'hFF
`define LIC_CLUSTER_HI 7
`define LIC_CLUSTER_LO 4
`endif

// ===== verification/lic_core_assertions.sv
// Port checker for the local interrupt controller core
`timescale 1ns/1ns
`include "lic_defs.vh"
module lic_core_chk #(
    parameter LATER_VARIANT = 1
)(
    input wire clk,
    input wire sys_rst,
    input wire sw_enable,
    input wire lvt_wr,
    input wire [7:0] err_evt,
    input wire msg_valid,
    input wire [2:0] msg_mode,
    input wire msg_deassert,
    input wire icr_go,
    input wire [2:0] icr_mode,
    input wire icr_deassert,
    input wire msg_accept,
    input wire msg_lowpri_bid,
    input wire rread_valid_r,
    input wire [4:0] lvt_mask_r,
    input wire [7:0] esr_r,
    input wire core_intr_r,
    input wire core_nmi_r,
    input wire core_init_r,
    input wire send_valid_r,
    input wire send_level_r,
    input wire [2:0] send_mode_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_edge_send;
        send_valid_r && !send_level_r && send_mode_r == $past(icr_mode);
    endsequence
    chk_dis_masks: assert property (!sw_enable |=> lvt_mask_r == 5'h1F)
        else $error("masks not set");
    chk_mask_hold: assert property (!lvt_wr |=> (lvt_mask_r & $past(lvt_mask_r)) == $past(lvt_mask_r))
        else $error("mask cleared");
    chk_dis_refuse: assert property (!sw_enable && msg_valid && msg_mode <= 3'h1 |-> !msg_accept)
        else $error("taken while disabled");
    chk_nmi_edge: assert property (msg_accept && msg_mode == `LIC_MODE_NMI |=> core_nmi_r)
        else $error("nmi lost");
    chk_init_edge: assert property (msg_accept && msg_mode == `LIC_MODE_INIT && !msg_deassert |=> core_init_r)
        else $error("init lost");
    chk_icr_edge: assert property (icr_go && !(icr_mode == `LIC_MODE_INIT && icr_deassert) |=> s_edge_send)
        else $error("bad send");
    chk_rread_none: assert property (LATER_VARIANT == 1 && msg_valid && msg_mode == `LIC_MODE_RREAD
        |-> !msg_accept ##1 !rread_valid_r)
        else $error("remote read served");
    chk_lowpri_slot: assert property (msg_lowpri_bid |-> msg_valid && sw_enable && !core_intr_r)
        else $error("bid with busy slot");
    chk_esr_log: assert property (|err_evt |=> (esr_r & $past(err_evt)) == $past(err_evt))
        else $error("error not logged");
endmodule
bind lic_core lic_core_chk #(.LATER_VARIANT(LATER_VARIANT)) chk_u (.*);

// ===== verification/lic_core_model.sv
// Processor core model that takes the pending interrupt
`timescale 1ns/1ns
module lic_core_model (
    input wire clk,
    input wire sys_rst,
    input wire core_intr_r,
    input wire slow,
    output logic core_ack
);
    logic [1:0] wait_r;
    // Slow holds the slot full so busy refusals can be seen
    always @(posedge clk)
    begin
        if (sys_rst || slow || !core_intr_r || core_ack)
        begin
            wait_r <= 2'h0;
            core_ack <= 1'b0;
        end
        else
        begin
            wait_r <= wait_r + 2'h1;
            core_ack <= wait_r == 2'h2;
        end
    end
endmodule

// ===== verification/lic_core_bench.sv
// Testbench for the local interrupt controller core
`timescale 1ns/1ns
`include "lic_defs.vh"
module lic_core_bench;
    logic clk = 0, sys_rst = 1, sw_enable = 0, focus_chk_en = 0, cluster_mode = 0, flat_cluster = 0;
    logic id_wr = 0, ldest_wr = 0, lvt_wr = 0, lvt_wr_mask = 0, local_pin0 = 0, local_pin1 = 1;
    logic perf_evt = 0, therm_evt = 0, esr_clear = 0, msg_valid = 0, msg_level = 0, msg_deassert = 0;
    logic msg_logical = 0, icr_go = 0, icr_level = 0, icr_deassert = 0, slow = 0;
    logic [1:0] pin_active_low = 2'h2;
    logic [2:0] lvt_wr_sel = 0, msg_mode = 0, icr_mode = 0;
    logic [7:0] id_wr_val = 0, ldest_wr_val = 0, lvt_wr_vec = 0, err_evt = 0, msg_dest = 0, msg_vec = 0;
    logic [7:0] icr_vec = 0, icr_dest = 0;
    wire core_ack, msg_accept, msg_lowpri_bid, msg_focus, rread_valid_r, core_intr_r, core_level_r;
    wire core_nmi_r, core_smi_r, core_init_r, core_start_r, send_valid_r, send_level_r;
    wire [2:0] send_mode_r;
    wire [4:0] lvt_mask_r;
    wire [7:0] rread_data_r, esr_r, id_r, ldest_r, core_vec_r, core_start_vec_r, send_vec_r, send_dest_r;
    int err_count = 0, total_checks = 0;
    lic_core dut_u (.*);
    lic_core_model model_u (.*);
    initial forever #20 clk = ~clk;
    task ck(string n, logic [7:0] s, logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task send(logic [2:0] m, logic [7:0] d, output logic [2:0] a);
        {msg_valid, msg_mode, msg_dest, msg_vec} = {1'b1, m, d, 8'h70};
        #2 a = {msg_accept, msg_lowpri_bid, msg_focus};
        @(posedge clk);
        #1;
    endtask
    // Bounded wait, then give the core model time to take the slot
    task want(logic [7:0] v);
        for (int k = 0; k < 20 && core_intr_r !== 1'b1; k++)
            cyc(1);
        ck("intr", core_intr_r, 1);
        ck("vec", core_vec_r, v);
        cyc(6);
    endtask
    task t_local;
        lvt_wr = 1;
        for (int i = 0; i < 5; i++)
        begin
            {lvt_wr_sel, lvt_wr_vec} = {i[2:0], 8'h40 + i[7:0]};
            cyc(1);
        end
        lvt_wr = 0;
        ck("mask", lvt_mask_r, 0);
        local_pin0 = 1;
        want(8'h40);
        local_pin1 = 0;
        want(8'h41);
        pulse(perf_evt);
        want(8'h43);
        pulse(therm_evt);
        want(8'h44);
        err_evt = 8'h04;
        cyc(1);
        err_evt = 0;
        ck("esr", esr_r, 8'h04);
        want(8'h42);
        pulse(esr_clear);
        ck("esr", esr_r, 0);
    endtask
    task t_dis;
        logic [2:0] a;
        {id_wr, id_wr_val} = {1'b1, 8'hA5};
        cyc(1);
        id_wr = 0;
        sw_enable = 0;
        cyc(2);
        ck("mask", lvt_mask_r, 8'h1F);
        ck("id", id_r, 8'hA5);
        send(`LIC_MODE_FIXED, 8'hA5, a);
        ck("fixed", a, 0);
        for (int m = 2; m < 7; m++)
        begin
            if (m == 3)
                continue;
            send(m[2:0], 8'hA5, a);
            ck("sys", a[2], 1);
            ck("pulse", {core_start_r, core_init_r, core_nmi_r, core_smi_r}, 8'h01 << (m == 2 ? 0 : m - 3));
        end
        ck("svec", core_start_vec_r, 8'h70);
        msg_deassert = 1;
        send(`LIC_MODE_INIT, 8'hA5, a);
        ck("deassert", {a[2], core_init_r}, 8'h02);
        {msg_valid, msg_deassert, sw_enable} = 3'h1;
        cyc(2);
        ck("mask", lvt_mask_r, 8'h1F);
    endtask
    task t_icr;
        icr_level = 1;
        for (int i = 0; i < 8; i++)
        begin
            {icr_go, icr_mode, icr_deassert} = {1'b1, i == 7 ? `LIC_MODE_INIT : i[2:0], i == 7};
            {icr_vec, icr_dest} = {8'h30 + i[7:0], 8'hC0 + i[7:0]};
            cyc(1);
            ck("svec", send_vec_r, icr_vec);
            ck("sdest", send_dest_r, icr_dest);
            ck("send", {send_valid_r, send_level_r, send_mode_r}, {i == 7, icr_mode} | 8'h10);
        end
        icr_go = 0;
    endtask
    task t_addr;
        logic [2:0] a;
        logic [10:0] tb [8] = '{11'h14B, 11'h148, 11'h421, 11'h404, 11'h663, 11'h664, 11'h642, 11'h7FF};
        {ldest_wr, ldest_wr_val, flat_cluster} = {1'b1, 8'h31, 1'b1};
        cyc(1);
        ldest_wr = 0;
        ck("ldest", ldest_r, 8'h31);
        foreach (tb[j])
        begin
            {msg_logical, cluster_mode} = tb[j][10:9];
            send(`LIC_MODE_NMI, tb[j][8:1], a);
            ck("hit", a[2], tb[j][0]);
        end
        {focus_chk_en, msg_logical, slow, msg_level} = 4'hB;
        send(`LIC_MODE_FIXED, 8'hA5, a);
        ck("fill", a, 8'h04);
        ck("level", core_level_r, 1);
        send(`LIC_MODE_LOWPRI, 8'hA5, a);
        ck("busy", a, 0);
        {msg_valid, slow} = 2'h0;
        cyc(8);
        send(`LIC_MODE_LOWPRI, 8'hA5, a);
        ck("free", a, 8'h06);
        send(`LIC_MODE_RREAD, 8'hA5, a);
        ck("rread", {a, rread_valid_r}, 0);
        ck("rdata", rread_data_r, 0);
        msg_valid = 0;
    endtask
    task finish_test;
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_count++;
        finish_test;
    end
    initial
    begin
        cyc(12);
        sys_rst = 0;
        sw_enable = 1;
        t_local;
        t_dis;
        t_icr;
        t_addr;
        finish_test;
    end
endmodule
